// ===== rtl/regbank_pkg.sv
// Constants for the serial control register bank
package regbank_pkg;
  // Register offsets (7-bit serial address)
  localparam logic [6:0] TOP_CONTROL_OFS       = 7'h00;
  localparam logic [6:0] TOP_CONTROL_RB_OFS    = 7'h01;
  localparam logic [6:0] CHANNEL_POWER_OFS     = 7'h02;
  localparam logic [6:0] OVERLOAD_CONTROL_OFS  = 7'h04;
  localparam logic [6:0] PLL_CONTROL_OFS       = 7'h08;
  localparam logic [6:0] CLOCK_HYSTERESIS_OFS  = 7'h0a;
  localparam logic [6:0] PATTERN_LOW_OFS       = 7'h10;
  localparam logic [6:0] PATTERN_HIGH_OFS      = 7'h12;
  localparam logic [6:0] FILTER_CLIPPING_OFS   = 7'h14;
  localparam logic [6:0] FILTER_CONTROL_OFS    = 7'h16;
  localparam logic [6:0] DRIVER_CONTROL_OFS    = 7'h18;
  localparam logic [6:0] CHIP_IDENTITY_OFS     = 7'h1e;
  // Word index of the read-only identity register
  localparam logic [3:0] CHIP_IDENTITY_IDX     = 4'hf;
  // One bit per word index that software may write
  localparam logic [15:0] WRITABLE_MASK        = 16'h1f37;
  // Identity value, arbitrary
  localparam logic [7:0] CHIP_IDENTITY_VAL     = 8'h5a;
  // Reset value of every configuration register
  localparam logic [7:0] CONFIG_RESET          = 8'h00;
  // Top control field positions
  localparam int FULL_POWER_DOWN_BIT   = 0;
  localparam int SLEEP_BIT             = 1;
  localparam int OPEN_DRAIN_BIT        = 2;
  localparam int SOFT_RESET_BIT        = 3;
  localparam int RATE_RANGE_BIT        = 4;
  localparam int READBACK_SELECT_BIT   = 5;
  // Frame layout in serial clock edges
  localparam logic [4:0] ADDR_LAST_BIT = 5'd7;
  localparam logic [4:0] DATA_FIRST    = 5'd8;
  localparam logic [4:0] DATA_LAST_BIT = 5'd15;
  localparam logic [4:0] FRAME_DONE    = 5'd16;
  // Soft reset duration
  localparam int SRST_TIME_NS  = 2000;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SRST_CYC      = (SRST_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [8:0] SRST_LAST = 9'(SRST_CYC - 1);
endpackage

// ===== rtl/regfile_if.sv
// Carrier between the serial front end and the register store
`timescale 1ns/10ps
`default_nettype none
interface regfile_if;
  logic       wr_en;
  logic [3:0] wr_idx;
  logic [7:0] wr_data;
  logic       rd_en;
  logic [3:0] rd_idx;
  logic [7:0] rd_data;
  logic [7:0] ctrl;
  modport front (output wr_en, wr_idx, wr_data, rd_en, rd_idx,
                 input rd_data, ctrl);
  modport store (input wr_en, wr_idx, wr_data, rd_en, rd_idx,
                 output rd_data, ctrl);
endinterface
`default_nettype wire

// ===== rtl/regbank_store.sv
// Register store on the serial clock with registered read data
`timescale 1ns/10ps
`default_nettype none
module regbank_store (
  input  wire logic  clk,
  input  wire logic  rst,
  regfile_if.store   bus
);
  typedef struct packed {
    logic [15:0][7:0] word;
    logic [7:0]       rd;
  } store_s;

  store_s st_q;
  store_s st_d;

  // Write writable words, capture read word, identity stays fixed
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < 16; i++) begin
      if (bus.wr_en && bus.wr_idx == 4'(i) &&
          regbank_pkg::WRITABLE_MASK[i]) begin
        st_d.word[i] = bus.wr_data;
      end
    end
    st_d.word[regbank_pkg::CHIP_IDENTITY_IDX] =
      regbank_pkg::CHIP_IDENTITY_VAL;
    if (bus.rd_en) begin
      st_d.rd = st_q.word[bus.rd_idx];
    end
  end

  // Hard or soft reset clears every word to 00h, the identity word included
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus.rd_data = st_q.rd;
  assign bus.ctrl    = st_q.word[0];

  a_read_word: assert property (@(posedge clk) disable iff (rst)
    bus.rd_en |=> bus.rd_data == $past(st_q.word[bus.rd_idx]))
    else $error("read word not captured");
endmodule
`default_nettype wire

// ===== rtl/spi_control_register_bank.sv
// Serial control register bank with top control register
// Operation
// - Raising select ends any transaction at once.
// - Aborted write changes nothing; aborted read may return wrong data.
// - Open-drain mode only pulls the data pad low.
// - Top control bit 2 selects push-pull or open-drain pad.
// - Top control is write-only, read via 01h when readback select set.
// - Bit 5 chooses between top control readback and all others.
// - Bit 4 selects the 40-45 or 45-50 sample-rate range.
// - Writing bit 3 resets the whole device like the reset pin.
// - Soft reset bit clears itself as soon as soft reset starts; soft reset ends after about 2 us.
// - Bit 1 enters sleep mode.
// - Bit 0 powers down the whole device.
// - All configuration registers reset to 00h on any reset.
// - Eight address-phase bits then eight data bits, MSB first.
// - Select activity resets only the frame state; registers keep their contents.
// - Even write-only registers read back at the next odd address.
`timescale 1ns/10ps
`default_nettype none
module spi_control_register_bank (
  input  wire logic  clk_sys,
  input  wire logic  sys_rst,
  input  wire logic  serial_clk,
  input  wire logic  select_n,
  input  wire logic  serial_io_in,
  output logic       serial_io_out,
  output logic       serial_io_oe,
  output logic       sample_rate_low_range,
  output logic       sleep_mode,
  output logic       full_power_down,
  output logic       pad_open_drain_enable,
  output logic       soft_reset_active
);
  typedef struct packed {
    logic [4:0] cnt;
    logic [6:0] sh;
    logic [6:0] addr;
    logic       rw;
  } link_s;

  typedef struct packed {
    logic [7:0] po;
    logic       out;
    logic       oe;
  } pad_s;

  typedef struct packed {
    logic [7:0] ctrl_s1;
    logic [7:0] ctrl_s2;
    logic       srst;
    logic [8:0] srst_cnt;
    logic       range;
    logic       sleep;
    logic       pd;
    logic       od;
  } sys_s;

  regfile_if rf ();

  link_s lk_q;
  link_s lk_d;
  pad_s  pd_q;
  pad_s  pd_d;
  sys_s  sy_q;
  sys_s  sy_d;
  logic  link_rst;
  logic  frame_rst;
  logic  readback_select;
  logic  od_mode;
  logic  readable;
  logic [7:0] visible;

  // Whole link side is reset by the pin or by the soft reset pulse
  assign link_rst  = sys_rst | sy_q.srst;
  // Select high ends the frame but leaves the store alone
  assign frame_rst = link_rst | select_n;

  regbank_store u_store (
    .clk (serial_clk),
    .rst (link_rst),
    .bus (rf)
  );

  assign readback_select     = rf.ctrl[regbank_pkg::READBACK_SELECT_BIT];
  assign od_mode = rf.ctrl[regbank_pkg::OPEN_DRAIN_BIT];

  // Which captured address may show data
  always_comb begin
    readable = 1'b0;
    if (lk_q.addr == regbank_pkg::TOP_CONTROL_RB_OFS) begin
      readable = readback_select;
    end else if (readback_select) begin
      readable = 1'b0;
    end else if (lk_q.addr[6:1] ==
                 regbank_pkg::CHIP_IDENTITY_OFS[6:1]) begin
      readable = 1'b1;
    end else if (lk_q.addr[0] && lk_q.addr[6:5] == 2'b00) begin
      readable = regbank_pkg::WRITABLE_MASK[lk_q.addr[4:1]];
    end
    visible = readable ? rf.rd_data : 8'h00;
  end

  // Serial shifter: address phase then data phase, MSB first
  always_comb begin
    lk_d       = lk_q;
    rf.wr_en   = 1'b0;
    rf.wr_idx  = lk_q.addr[4:1];
    rf.wr_data = {lk_q.sh, serial_io_in};
    rf.rd_en   = 1'b0;
    rf.rd_idx  = lk_q.sh[4:1];
    if (lk_q.cnt != regbank_pkg::FRAME_DONE) begin
      lk_d.cnt = lk_q.cnt + 5'd1;
      lk_d.sh  = {lk_q.sh[5:0], serial_io_in};
    end
    if (lk_q.cnt == regbank_pkg::ADDR_LAST_BIT) begin
      lk_d.addr = lk_q.sh;
      lk_d.rw   = serial_io_in;
      rf.rd_en  = 1'b1;
    end
    // Commit only on the last data bit of a write with select low
    if (lk_q.cnt == regbank_pkg::DATA_LAST_BIT && !lk_q.rw &&
        lk_q.addr[6:5] == 2'b00 && !lk_q.addr[0]) begin
      rf.wr_en = 1'b1;
    end
  end

  // Frame state, cleared whenever select goes high
  always_ff @(posedge serial_clk or posedge frame_rst) begin
    if (frame_rst) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  // Read data driver, changes on falling serial clock edges
  always_comb begin
    pd_d = '0;
    if (lk_q.rw && lk_q.cnt >= regbank_pkg::DATA_FIRST &&
        lk_q.cnt <= regbank_pkg::DATA_LAST_BIT) begin
      if (lk_q.cnt == regbank_pkg::DATA_FIRST) begin
        pd_d.po = visible;
      end else begin
        pd_d.po = {pd_q.po[6:0], 1'b0};
      end
      if (od_mode) begin
        pd_d.out = 1'b0;
        pd_d.oe  = ~pd_d.po[7];
      end else begin
        pd_d.out = pd_d.po[7];
        pd_d.oe  = 1'b1;
      end
    end
  end

  always_ff @(negedge serial_clk or posedge frame_rst) begin
    if (frame_rst) begin
      pd_q <= '0;
    end else begin
      pd_q <= pd_d;
    end
  end

  assign serial_io_out = pd_q.out;
  assign serial_io_oe  = pd_q.oe;

  // System side: sync control byte, run soft reset timer
  always_comb begin
    sy_d         = sy_q;
    sy_d.ctrl_s1 = rf.ctrl;
    sy_d.ctrl_s2 = sy_q.ctrl_s1;
    if (sy_q.srst) begin
      if (sy_q.srst_cnt == regbank_pkg::SRST_LAST) begin
        sy_d.srst     = 1'b0;
        sy_d.srst_cnt = 9'd0;
      end else begin
        sy_d.srst_cnt = sy_q.srst_cnt + 9'd1;
      end
    end else if (sy_q.ctrl_s2[regbank_pkg::SOFT_RESET_BIT]) begin
      sy_d.srst = 1'b1;
    end
    sy_d.range = sy_q.ctrl_s2[regbank_pkg::RATE_RANGE_BIT];
    sy_d.sleep = sy_q.ctrl_s2[regbank_pkg::SLEEP_BIT];
    sy_d.pd    = sy_q.ctrl_s2[regbank_pkg::FULL_POWER_DOWN_BIT];
    sy_d.od    = sy_q.ctrl_s2[regbank_pkg::OPEN_DRAIN_BIT];
    if (sy_q.srst) begin
      sy_d.ctrl_s1 = '0;
      sy_d.ctrl_s2 = '0;
      sy_d.range   = 1'b0;
      sy_d.sleep   = 1'b0;
      sy_d.pd      = 1'b0;
      sy_d.od      = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sy_q <= '0;
    end else begin
      sy_q <= sy_d;
    end
  end

  assign sample_rate_low_range = sy_q.range;
  assign sleep_mode            = sy_q.sleep;
  assign full_power_down       = sy_q.pd;
  assign pad_open_drain_enable = sy_q.od;
  assign soft_reset_active     = sy_q.srst;

  a_abort_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
    select_n |-> lk_q.cnt == 5'd0 && !pd_q.oe)
    else $error("frame not ended by select high");
  a_od_low_only: assert property (@(negedge serial_clk)
    disable iff (frame_rst)
    od_mode && pd_q.oe |-> !pd_q.out)
    else $error("open drain pad driven high");
  a_pp_drives: assert property (@(negedge serial_clk)
    disable iff (frame_rst)
    !od_mode && lk_q.rw && lk_q.cnt == 5'd9 |-> pd_q.oe)
    else $error("push-pull pad not driven");
  a_first_bit_msb: assert property (@(negedge serial_clk)
    disable iff (frame_rst)
    lk_q.rw && lk_q.cnt == 5'd8 |=> pd_q.po == visible)
    else $error("read byte not loaded");
  a_cbr_hides: assert property (@(posedge serial_clk)
    disable iff (frame_rst)
    readback_select && lk_q.addr != 7'h01 |-> visible == 8'h00)
    else $error("hidden register visible");
  a_write_full: assert property (@(posedge serial_clk)
    disable iff (frame_rst)
    rf.wr_en |-> lk_q.cnt == 5'd15 && !lk_q.rw)
    else $error("write before last data bit");
  a_srst_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sy_q.srst && sy_q.ctrl_s2[3] |=> sy_q.srst)
    else $error("soft reset not started");
  a_srst_ends: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sy_q.srst && sy_q.srst_cnt == 9'd499 |=> !sy_q.srst)
    else $error("soft reset length wrong");
  a_srst_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sy_q.srst ##1 sy_q.srst |-> !sleep_mode && !full_power_down)
    else $error("controls kept through soft reset");
  a_mode_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sy_q.srst && $stable(sy_q.ctrl_s2) |=>
    sleep_mode == $past(sy_q.ctrl_s2[1]))
    else $error("sleep output not following");

  c_write: cover property (@(posedge serial_clk) rf.wr_en);
  c_read_od: cover property (@(negedge serial_clk) od_mode && pd_q.oe);
  c_srst: cover property (@(posedge clk_sys) $fell(sy_q.srst));
  c_abort: cover property (@(posedge serial_clk)
    lk_q.cnt == 5'd10 ##1 select_n);
endmodule
`default_nettype wire

// ===== verification/spi_host_model.sv
// Host controller model driving the three-wire serial link
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  output logic      serial_clk,
  output logic      select_n,
  output logic      host_out,
  output logic      host_oe,
  input  wire logic wire_in
);
  // Link idles with select high and the clock stopped
  initial begin
    serial_clk = 1'b0;
    select_n   = 1'b1;
    host_out   = 1'b1;
    host_oe    = 1'b0;
  end

  // One frame of n bits; fewer than 16 cuts it short
  task automatic frame(input logic [6:0] a, input logic rw,
                       input logic [7:0] d, input int n,
                       output logic [7:0] r);
    logic [15:0] sh;
    sh = {a, rw, d};
    r = 8'h00;
    select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      host_oe  = !(rw && i >= 8);
      host_out = sh[15-i];
      #62.5 serial_clk = 1'b1;
      if (i >= 8) r = {r[6:0], wire_in};
      #62.5 serial_clk = 1'b0;
    end
    host_oe = 1'b0;
    #62.5 select_n = 1'b1;
    #125;
  endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the serial control register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk_sys;
  logic        sys_rst;
  logic        serial_clk;
  logic        select_n;
  logic        host_out;
  logic        host_oe;
  logic        sio;
  logic        tog;
  logic        dev_out;
  logic        dev_oe;
  logic        rate_lo;
  logic        sleep;
  logic        pwr_dn;
  logic        od_en;
  logic        srst;
  logic [7:0]  shadow [16];
  logic [15:0] rnd;
  logic [15:0] srst_cnt;
  int          error_cnt;
  int          checks_done;
  int          cyc;

  // Pull-up only in open-drain mode, else a floating line toggles
  assign sio = host_oe ? host_out : dev_oe ? dev_out :
               shadow[0][2] ? 1'b1 : tog;

  spi_control_register_bank u_spi_control_register_bank (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .serial_clk(serial_clk),
    .select_n(select_n), .serial_io_in(sio), .serial_io_out(dev_out),
    .serial_io_oe(dev_oe), .sample_rate_low_range(rate_lo),
    .sleep_mode(sleep), .full_power_down(pwr_dn),
    .pad_open_drain_enable(od_en), .soft_reset_active(srst));

  spi_host_model u_spi_host_model (
    .serial_clk(serial_clk), .select_n(select_n),
    .host_out(host_out), .host_oe(host_oe), .wire_in(sio));

  // System clock
  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;
  always @(negedge clk_sys) tog <= ~tog;

  task automatic fail(input string msg);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) fail($sformatf("got %h exp %h", got, exp));
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Timeout, soft reset length and open-drain pad watch
  always @(posedge clk_sys) begin
    cyc++;
    if (srst === 1'b1) srst_cnt++;
    if (od_en === 1'b1 && dev_oe === 1'b1 && dev_out !== 1'b0)
      fail("pad driven high");
    if (cyc == 80000) begin
      error_cnt++;
      end_sim();
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected read data from the shadow copy
  function automatic logic [7:0] exp_rd(input logic [6:0] a);
    if (a >= 7'h20) return 8'h00;
    if (shadow[0][5]) return (a == 7'h01) ? shadow[0] : 8'h00;
    if (a >= 7'h1e) return regbank_pkg::CHIP_IDENTITY_VAL;
    if (a == 7'h01) return 8'h00;
    return regbank_pkg::WRITABLE_MASK[a[4:1]] ? shadow[a[4:1]] : 8'h00;
  endfunction

  task automatic xfer(input logic [6:0] a, input logic rw,
                      input logic [7:0] d, input int n);
    logic [7:0] r;
    @(negedge clk_sys);
    #1.3;
    u_spi_host_model.frame(a, rw, d, n, r);
    if (rw && n == 16) chk({8'h00, r}, {8'h00, exp_rd(a)});
    if (!rw && n == 16 && !a[0] && a < 7'h20 &&
        regbank_pkg::WRITABLE_MASK[a[4:1]])
      shadow[a[4:1]] = d;
  endtask

  task automatic chk_ctrl();
    repeat (10) @(negedge clk_sys);
    chk({11'h000, srst, rate_lo, od_en, sleep, pwr_dn},
        {11'h000, 1'b0, shadow[0][4], shadow[0][2], shadow[0][1:0]});
  endtask

  task automatic rd_all();
    for (int i = 0; i < 17; i++)
      xfer({i[5:0], 1'b1}, 1'b1, 8'h00, 16);
  endtask

  task automatic clr();
    foreach (shadow[i]) shadow[i] = 8'h00;
  endtask

  initial begin
    sys_rst = 1'b1;
    tog = 1'b0;
    rnd = 16'h5ad9;
    srst_cnt = 16'h0000;
    clr();
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk_ctrl();
    rd_all();
    $display("test reset done");
    // Random writes to writable words, refused writes, readback
    for (int n = 0; n < 20; n++) begin
      do rnd = lfsr_next(rnd);
      while (rnd[3:0] == 4'h0 || !regbank_pkg::WRITABLE_MASK[rnd[3:0]]);
      xfer({2'b00, rnd[3:0], 1'b0}, 1'b0, rnd[15:8], 16);
    end
    xfer(7'h03, 1'b0, 8'hff, 16);
    xfer(7'h1e, 1'b0, 8'hff, 16);
    rd_all();
    $display("test regs done");
    // Top control fields with readback select set
    for (int m = 0; m < 4; m++) begin
      rnd = lfsr_next(rnd);
      xfer(7'h00, 1'b0, {3'b001, m[1], 1'b0, m[0], rnd[1:0]}, 16);
      chk_ctrl();
      xfer(7'h01, 1'b1, 8'h00, 16);
      xfer(7'h03, 1'b1, 8'h00, 16);
    end
    xfer(7'h00, 1'b0, 8'h00, 16);
    xfer(7'h01, 1'b1, 8'h00, 16);
    $display("test top done");
    // Aborted write and read frames
    xfer(7'h02, 1'b0, 8'ha5, 16);
    xfer(7'h02, 1'b0, 8'h3c, 12);
    xfer(7'h03, 1'b1, 8'h00, 16);
    xfer(7'h03, 1'b1, 8'h00, 5);
    xfer(7'h03, 1'b1, 8'h00, 16);
    $display("test abort done");
    // Soft reset clears everything and ends by itself
    srst_cnt = 16'h0000;
    xfer(7'h00, 1'b0, 8'h08, 16);
    for (int i = 0; i < 2000 && srst !== 1'b0; i++) @(negedge clk_sys);
    chk(srst_cnt, 16'(regbank_pkg::SRST_CYC));
    clr();
    chk_ctrl();
    rd_all();
    $display("test soft reset done");
    // Hardware reset in mid-run
    xfer(7'h04, 1'b0, 8'h3c, 16);
    xfer(7'h00, 1'b0, 8'h17, 16);
    @(negedge clk_sys) sys_rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b0;
    clr();
    chk_ctrl();
    rd_all();
    $display("test hard reset done");
    end_sim();
  end
endmodule
`default_nettype wire
